// ==== core/pic_regs.vh ====
// Register offsets, field positions and reset values of the peripheral interrupt control block
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

`define PIC_ADDR_PRIO_A 16'hFF20
`define PIC_ADDR_PRIO_B 16'hFF21
`define PIC_ADDR_EN_TB 16'hFF22
`define PIC_ADDR_EN_SER 16'hFF23
`define PIC_ADDR_EN_KEY 16'hFF24
`define PIC_ADDR_EN_TMR 16'hFF25
`define PIC_ADDR_FLG_TB 16'hFF26
`define PIC_ADDR_FLG_SER 16'hFF27
`define PIC_ADDR_FLG_KEY 16'hFF28
`define PIC_ADDR_FLG_TMR 16'hFF29
`define PIC_ADDR_BUS_MODE 16'hFF00
`define PIC_ADDR_STACK_PAGE 16'hFF01

`define PIC_RST_VAL 8'h00
`define PIC_MASK_PRIO_A 8'hFF
`define PIC_MASK_PRIO_B 8'hFC
`define PIC_MASK_EN_TB 8'hFF
`define PIC_MASK_EN_SER 8'h07
`define PIC_MASK_EN_KEY 8'hFF
`define PIC_MASK_EN_TMR 8'hFF
`define PIC_MASK_FLG_TB 8'h7F
`define PIC_MASK_FLG_SER 8'h07
`define PIC_MASK_FLG_KEY 8'hFF
`define PIC_MASK_FLG_TMR 8'hFF

`define PIC_POS_LVL_KEY 6
`define PIC_POS_LVL_SER 4
`define PIC_POS_LVL_SW 2
`define PIC_POS_LVL_CLK 0
`define PIC_POS_LVL_UPT 4
`define PIC_POS_LVL_LPT 2

`endif

// ==== core/pic_flag_reg.v ====
// Bank of eight write-one-to-clear event flags with set priority over clear
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"

module pic_flag_reg
#(
   parameter [7:0] MASK = 8'hFF
)
(
   input wire clk,
   input wire rst,
   input wire [7:0] set_pulse,
   input wire clr_we,
   input wire [7:0] clr_data,
   output wire [7:0] flags
);

reg [7:0] flag_r;
wire [7:0] flag_nxt;

genvar i;
generate
   for (i = 0; i < 8; i = i + 1)
   begin : g_bit
      // Event wins over a clear landing in the same cycle
      assign flag_nxt[i] = MASK[i] & (set_pulse[i] | (flag_r[i] & ~(clr_we & clr_data[i])));
   end
endgenerate

always @(posedge clk)
begin
   if (rst)
      flag_r <= `PIC_RST_VAL;
   else
      flag_r <= flag_nxt;
end

assign flags = flag_r;

endmodule
`default_nettype wire

// ==== core/pic_top.v ====
// Peripheral interrupt control: priorities, enables, factor flags and CPU request
//
// Contract
// - Key, serial, stopwatch, clock-timer groups have 2-bit priority levels, reset zero.
// - Timers 3-2 and timers 1-0 share one 2-bit priority each, reset zero.
// - Stopwatch 100, 10, 1 Hz causes have read/write enables, reset zero.
// - Clock timer 32, 8, 2, 1 Hz causes have read/write enables, reset zero.
// - Serial error, receive, transmit enables sit in bits 2..0, reset zero.
// - Eight key line enables, line 7 in bit 7 to line 0 in bit 0.
// - Underflow and compare-match enables per timer, timer 3 at top, reset zero.
// - Stopwatch and clock-timer flags set on event, write one clears, reset zero.
// - Serial flags set on event, write one clears, write zero ignored, reset zero.
// - Eight key flags set on event, write one clears, reset zero.
// - Timer underflow and compare-match flags per timer, write one clears, reset zero.
// - All interrupts blocked until bus-mode and stack-page registers both written.
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"

module pic_top
(
   input wire CLK_SYS,
   input wire RST,
   input wire [15:0] ADDR,
   input wire WR_EN,
   input wire RD_EN,
   input wire [7:0] WDATA,
   output reg [7:0] RDATA,
   output wire RD_HIT,
   input wire [2:0] SW_EVENT,
   input wire [3:0] CLK_TIMER_EVENT,
   input wire [2:0] SERIAL_EVENT,
   input wire [7:0] KEY_INPUT_LINES_EVENT,
   input wire [7:0] TIMER_EVENT,
   output wire IRQ_REQ,
   output wire [1:0] IRQ_LEVEL,
   output wire [2:0] IRQ_GROUP
);

// ==========================================================
// Address decode
// Full 16-bit compare; bank bits above the low word never reach this block
function hit;
   input [15:0] a;
   input [15:0] target;
   begin
      hit = (a == target);
   end
endfunction

// ==========================================================
// Priority and enable registers
reg [7:0] prio_a_r;
reg [7:0] prio_b_r;
reg [7:0] en_tb_r;
reg [7:0] en_ser_r;
reg [7:0] en_key_r;
reg [7:0] en_tmr_r;
// The lock only opens on the set-up writes; reset alone closes it again
reg bus_mode_seen_r;
reg stack_page_seen_r;

always @(posedge CLK_SYS)
begin
   if (RST)
   begin
      prio_a_r <= `PIC_RST_VAL;
      prio_b_r <= `PIC_RST_VAL;
      en_tb_r <= `PIC_RST_VAL;
      en_ser_r <= `PIC_RST_VAL;
      en_key_r <= `PIC_RST_VAL;
      en_tmr_r <= `PIC_RST_VAL;
      bus_mode_seen_r <= 1'b0;
      stack_page_seen_r <= 1'b0;
   end
   else if (WR_EN)
   begin
      // Reserved read/write bits FF21[7:6] and FF22[7] are stored but drive nothing
      if (hit(ADDR, `PIC_ADDR_PRIO_A))
         prio_a_r <= WDATA & `PIC_MASK_PRIO_A;
      if (hit(ADDR, `PIC_ADDR_PRIO_B))
         prio_b_r <= WDATA & `PIC_MASK_PRIO_B;
      if (hit(ADDR, `PIC_ADDR_EN_TB))
         en_tb_r <= WDATA & `PIC_MASK_EN_TB;
      if (hit(ADDR, `PIC_ADDR_EN_SER))
         en_ser_r <= WDATA & `PIC_MASK_EN_SER;
      if (hit(ADDR, `PIC_ADDR_EN_KEY))
         en_key_r <= WDATA & `PIC_MASK_EN_KEY;
      if (hit(ADDR, `PIC_ADDR_EN_TMR))
         en_tmr_r <= WDATA & `PIC_MASK_EN_TMR;
      // Watch the CPU set-up writes; the registers themselves live elsewhere
      if (hit(ADDR, `PIC_ADDR_BUS_MODE))
         bus_mode_seen_r <= 1'b1;
      if (hit(ADDR, `PIC_ADDR_STACK_PAGE))
         stack_page_seen_r <= 1'b1;
   end
end

// ==========================================================
// Factor flags
// Flags latch every event even while its enable is low, so software can poll
wire [7:0] flg_tb;
wire [7:0] flg_ser;
wire [7:0] flg_key;
wire [7:0] flg_tmr;

pic_flag_reg #(.MASK(`PIC_MASK_FLG_TB)) u_flg_tb
(
   .clk(CLK_SYS),
   .rst(RST),
   .set_pulse({1'b0, SW_EVENT, CLK_TIMER_EVENT}),
   .clr_we(WR_EN & hit(ADDR, `PIC_ADDR_FLG_TB)),
   .clr_data(WDATA),
   .flags(flg_tb)
);

pic_flag_reg #(.MASK(`PIC_MASK_FLG_SER)) u_flg_ser
(
   .clk(CLK_SYS),
   .rst(RST),
   .set_pulse({5'h00, SERIAL_EVENT}),
   .clr_we(WR_EN & hit(ADDR, `PIC_ADDR_FLG_SER)),
   .clr_data(WDATA),
   .flags(flg_ser)
);

pic_flag_reg #(.MASK(`PIC_MASK_FLG_KEY)) u_flg_key
(
   .clk(CLK_SYS),
   .rst(RST),
   .set_pulse(KEY_INPUT_LINES_EVENT),
   .clr_we(WR_EN & hit(ADDR, `PIC_ADDR_FLG_KEY)),
   .clr_data(WDATA),
   .flags(flg_key)
);

pic_flag_reg #(.MASK(`PIC_MASK_FLG_TMR)) u_flg_tmr
(
   .clk(CLK_SYS),
   .rst(RST),
   .set_pulse(TIMER_EVENT),
   .clr_we(WR_EN & hit(ADDR, `PIC_ADDR_FLG_TMR)),
   .clr_data(WDATA),
   .flags(flg_tmr)
);

// ==========================================================
// Read mux; unmapped bits and addresses read zero
// Combinational so a read costs no wait state; the price is a long path
// from ADDR through the decode to RDATA
reg rd_hit_c;
always @*
begin
   RDATA = 8'h00;
   rd_hit_c = 1'b1;
   case (ADDR)
      `PIC_ADDR_PRIO_A: RDATA = prio_a_r;
      `PIC_ADDR_PRIO_B: RDATA = prio_b_r;
      `PIC_ADDR_EN_TB: RDATA = en_tb_r;
      `PIC_ADDR_EN_SER: RDATA = en_ser_r;
      `PIC_ADDR_EN_KEY: RDATA = en_key_r;
      `PIC_ADDR_EN_TMR: RDATA = en_tmr_r;
      `PIC_ADDR_FLG_TB: RDATA = flg_tb;
      `PIC_ADDR_FLG_SER: RDATA = flg_ser;
      `PIC_ADDR_FLG_KEY: RDATA = flg_key;
      `PIC_ADDR_FLG_TMR: RDATA = flg_tmr;
      default: rd_hit_c = 1'b0;
   endcase
end
assign RD_HIT = RD_EN & rd_hit_c;

// ==========================================================
// Request arbitration, highest level wins, fixed order on ties
wire [1:0] lvl_key = prio_a_r[`PIC_POS_LVL_KEY +: 2];
wire [1:0] lvl_ser = prio_a_r[`PIC_POS_LVL_SER +: 2];
wire [1:0] lvl_sw = prio_a_r[`PIC_POS_LVL_SW +: 2];
wire [1:0] lvl_clk = prio_a_r[`PIC_POS_LVL_CLK +: 2];
wire [1:0] lvl_upt = prio_b_r[`PIC_POS_LVL_UPT +: 2];
wire [1:0] lvl_lpt = prio_b_r[`PIC_POS_LVL_LPT +: 2];

wire [5:0] pend;
assign pend[0] = |(flg_key & en_key_r);
assign pend[1] = |(flg_ser & en_ser_r);
assign pend[2] = |(flg_tb[6:4] & en_tb_r[6:4]);
assign pend[3] = |(flg_tb[3:0] & en_tb_r[3:0]);
assign pend[4] = |(flg_tmr[7:4] & en_tmr_r[7:4]);
assign pend[5] = |(flg_tmr[3:0] & en_tmr_r[3:0]);

wire [11:0] lvls = {lvl_lpt, lvl_upt, lvl_clk, lvl_sw, lvl_ser, lvl_key};
reg [1:0] best_lvl;
reg [2:0] best_grp;
integer g;
// Ties go to the lower group index, so the winner is fixed for any flag pattern
always @*
begin
   best_lvl = 2'h0;
   best_grp = 3'h0;
   for (g = 5; g >= 0; g = g - 1)
   begin
      // Level zero never requests
      if (pend[g] && lvls[2*g +: 2] != 2'h0 && lvls[2*g +: 2] >= best_lvl)
      begin
         best_lvl = lvls[2*g +: 2];
         best_grp = g[2:0];
      end
   end
end

// The lock gates the request, level and group outputs; flags keep collecting while it is closed
wire unlocked = bus_mode_seen_r & stack_page_seen_r;
assign IRQ_REQ = unlocked & (best_lvl != 2'h0);
assign IRQ_LEVEL = IRQ_REQ ? best_lvl : 2'h0;
assign IRQ_GROUP = IRQ_REQ ? best_grp : 3'h0;

endmodule
`default_nettype wire

// ==== tb/pic_checker.sv ====
// Port checks for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module pic_checker
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [15:0] ADDR,
   input wire logic WR_EN,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] RDATA,
   input wire logic [7:0] KEY_INPUT_LINES_EVENT,
   input wire logic IRQ_REQ,
   input wire logic [1:0] IRQ_LEVEL,
   input wire logic [2:0] IRQ_GROUP
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   key_flag_set_a: assert property (!$past(RST) && ADDR == 16'hFF28
      |-> (RDATA & $past(KEY_INPUT_LINES_EVENT)) == $past(KEY_INPUT_LINES_EVENT)) else $error("key flag lost");
   key_flag_clear_a: assert property (!$past(RST) && $past(WR_EN) && $past(ADDR) == 16'hFF28
      && ADDR == 16'hFF28 |-> (RDATA & $past(WDATA) & ~$past(KEY_INPUT_LINES_EVENT)) == 8'h00)
      else $error("flag kept");
   serial_unused_a: assert property (ADDR == 16'hFF23 || ADDR == 16'hFF27 |-> RDATA[7:3] == 5'h00)
      else $error("serial spare bits");
   prio_unused_a: assert property (ADDR == 16'hFF21 |-> RDATA[1:0] == 2'h0) else $error("prio spare");
   unmapped_zero_a: assert property (ADDR < 16'hFF20 || ADDR > 16'hFF29 |-> RDATA == 8'h00)
      else $error("unmapped read");
   key_enable_a: assert property (!$past(RST) && $past(WR_EN) && $past(ADDR) == 16'hFF24
      && ADDR == 16'hFF24 |-> RDATA == $past(WDATA)) else $error("key enable write");
   level_valid_a: assert property (IRQ_REQ |-> IRQ_LEVEL != 2'h0) else $error("zero level request");
   key_level_a: assert property (IRQ_REQ && IRQ_GROUP == 3'h0 && ADDR == 16'hFF20
      |-> IRQ_LEVEL == RDATA[7:6]) else $error("key level");
   reset_quiet_a: assert property ($past(RST) |-> !IRQ_REQ) else $error("request after reset");
   cover property (IRQ_REQ && IRQ_GROUP == 3'h1);
   cover property ($rose(IRQ_REQ));
   cover property (WR_EN && ADDR == 16'hFF28 && KEY_INPUT_LINES_EVENT != 8'h00);
endmodule
bind pic_top pic_checker chk (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR_EN(WR_EN), .WDATA(WDATA),
   .RDATA(RDATA), .KEY_INPUT_LINES_EVENT(KEY_INPUT_LINES_EVENT), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
   .IRQ_GROUP(IRQ_GROUP));
`default_nettype wire

// ==== tb/pic_cpu_model.sv ====
// CPU side of the I/O bus, driving at the falling edge
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model
(
   input wire logic clk,
   output logic [15:0] addr,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rd_hit
);
   initial
   begin
      addr = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = 8'h00;
   end
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      // Stale data is inverted so a late write never sees a harmless copy
      wdata = ~d;
   endtask
   task rd(input logic [15:0] a, output logic [7:0] d, output logic h);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      // Data and hit are taken at the rising edge that closes the read cycle
      @(posedge clk);
      d = rdata;
      h = rd_hit;
      @(negedge clk);
      rd_en = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== tb/peripheral_interrupt_control_tb_top.sv ====
// Self-checking bench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_control_tb_top;
   logic clk = 1'b0, rst = 1'b1, wr_en, rd_en, irq, hit;
   logic [2:0] sw = 3'h0, se = 3'h0, grp;
   logic [3:0] ct = 4'h0;
   logic [7:0] ke = 8'h00, te = 8'h00, wdata, rdata, d;
   logic [15:0] addr;
   logic [1:0] lvl;
   int bad_count = 0, tests_run = 0, cyc = 0;
   always #2.5 clk = ~clk;
   pic_cpu_model cpu (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
      .rd_hit(hit));
   pic_top dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
      .RDATA(rdata), .RD_HIT(hit), .SW_EVENT(sw), .CLK_TIMER_EVENT(ct), .SERIAL_EVENT(se),
      .KEY_INPUT_LINES_EVENT(ke), .TIMER_EVENT(te), .IRQ_REQ(irq), .IRQ_LEVEL(lvl), .IRQ_GROUP(grp));
   task test_done;
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         test_done;
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rc(input logic [15:0] a, input logic [7:0] exp);
      logic h;
      cpu.rd(a, d, h);
      chk(d, exp);
      chk({7'h00, h}, {7'h00, (a >= 16'hFF20 && a <= 16'hFF29)});
   endtask
   task ci(input logic [7:0] exp);
      chk({2'h0, irq, lvl, grp}, exp);
   endtask
   // Peripheral event pulses, one cycle wide
   task ev(input logic [7:0] k, input logic [7:0] o);
      @(negedge clk);
      ke = k;
      {te, ct, se, sw} = {o, o[3:0], o[2:0], o[2:0]};
      @(negedge clk);
      ke = 8'h00;
      {te, ct, se, sw} = 18'h0;
   endtask
   // ====================
   // Scenarios
   task t_reset;
      for (int i = 0; i < 11; i++)
         rc(16'hFF20 + 16'(i), 8'h00);
   endtask
   task t_flags;
      ev(8'hFF, 8'hFF);
      rc(16'hFF26, 8'h7F);
      rc(16'hFF27, 8'h07);
      cpu.wr(16'hFF28, 8'h00);
      rc(16'hFF28, 8'hFF);
      rc(16'hFF29, 8'hFF);
      for (int i = 6; i < 10; i++)
         cpu.wr(16'hFF20 + 16'(i), 8'h55);
      rc(16'hFF26, 8'h2A);
      rc(16'hFF27, 8'h02);
      rc(16'hFF28, 8'hAA);
      rc(16'hFF29, 8'hAA);
   endtask
   task t_rw;
      for (int i = 0; i < 11; i++)
      begin
         cpu.wr(16'hFF20 + 16'(i), 8'hFF);
         if (i < 6)
            rc(16'hFF20 + 16'(i), (i == 1) ? 8'hFC : (i == 3) ? 8'h07 : 8'hFF);
      end
      rc(16'hFF2A, 8'h00);
      rc(16'hFF28, 8'h00);
   endtask
   task t_irq;
      cpu.wr(16'hFF20, 8'hC0);
      cpu.wr(16'hFF21, 8'h00);
      ev(8'h01, 8'h00);
      ci(8'h00);
      cpu.wr(16'hFF00, 8'h00);
      ci(8'h00);
      cpu.wr(16'hFF01, 8'h00);
      ci(8'h38);
      cpu.wr(16'hFF20, 8'h00);
      ci(8'h00);
      cpu.wr(16'hFF20, 8'hF0);
      fork
         cpu.wr(16'hFF28, 8'h01);
         ev(8'h01, 8'h04);
      join
      rc(16'hFF28, 8'h01);
      cpu.wr(16'hFF28, 8'h01);
      ci(8'h39);
   endtask
   task t_groups;
      cpu.wr(16'hFF27, 8'h07);
      ci(8'h00);
      cpu.wr(16'hFF21, 8'h0C);
      ci(8'h3D);
      cpu.wr(16'hFF20, 8'h05);
      ci(8'h3D);
      cpu.wr(16'hFF21, 8'h00);
      ci(8'h2A);
      cpu.wr(16'hFF26, 8'h40);
      ci(8'h2B);
      cpu.wr(16'hFF22, 8'h00);
      ci(8'h00);
      rc(16'hFF26, 8'h04);
      ev(8'h00, 8'h80);
      cpu.wr(16'hFF21, 8'h10);
      ci(8'h2C);
      cpu.wr(16'hFF25, 8'h7F);
      ci(8'h00);
   endtask
   task t_rerst;
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rc(16'hFF29, 8'h00);
      rc(16'hFF25, 8'h00);
      cpu.wr(16'hFF20, 8'hC0);
      cpu.wr(16'hFF24, 8'h01);
      ev(8'h01, 8'h00);
      ci(8'h00);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_flags;
      t_rw;
      t_irq;
      t_groups;
      t_rerst;
      test_done;
   end
endmodule
`default_nettype wire
